// file: inc/jtpps_params.svh
// Constants for the shared-pin boundary-scan test port.
// Assumes inclusion by bare name; definitions only.
// Behaviour
// - Test-select low hands five shared pins to test port, halts normal work.
// - State machine and registers follow the 2001 boundary-scan standard.
// - Decoder supports IDCODE, BYPASS, EXTEST, SAMPLE, PRELOAD, HIGHZ, CLAMP.
// - Pin 0 test clock, 1 mode, 2 data in, 3 data out, 4 test reset.
// - Test-select high leaves the five pins as ordinary general-purpose pins.
// - IDCODE shifts out a fixed hard-wired identification code.
`ifndef JTPPS_PARAMS_SVH
`define JTPPS_PARAMS_SVH
`define JTPPS_IR_LEN      4
`define JTPPS_IR_EXTEST   4'h0
`define JTPPS_IR_SAMPLE   4'h1
`define JTPPS_IR_PRELOAD  4'h2
`define JTPPS_IR_IDCODE   4'h3
`define JTPPS_IR_CLAMP    4'h4
`define JTPPS_IR_HIGHZ    4'h5
`define JTPPS_IR_BYPASS   4'hF
`define JTPPS_IR_CAPTURE  4'h1
`define JTPPS_GPIO_TCK    0
`define JTPPS_GPIO_TMS    1
`define JTPPS_GPIO_TDI    2
`define JTPPS_GPIO_TDO    3
`define JTPPS_GPIO_TRST   4
`define JTPPS_GPIO_COUNT  5
// Arbitrary identification value, not a real part code
`define JTPPS_IDCODE      32'h1234_5001
`endif

// file: inc/jtpps_pkg.sv
// Types for the shared-pin boundary-scan test port.
// Assumes nothing outside itself.
package jtpps_pkg;
    // Gray steps along the main paths of the standard controller
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SDS = 4'h3, CDR = 4'h2,
        SDR = 4'h6, E1D = 4'h7, PDR = 4'h5, E2D = 4'h4,
        UDR = 4'hC, SIS = 4'hD, CIR = 4'hF, SIR = 4'hE,
        E1I = 4'hA, PIR = 4'hB, E2I = 4'h9, UIR = 4'h8
    } jtpps_state_t;
endpackage

// file: rtl/jtpps_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes levels from outside the sys_clk domain.
`timescale 1ns/1ps
module jtpps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,  // System clock
    input  wire logic             srst,     // Synchronous reset
    input  wire logic [WIDTH-1:0] asyncIn,  // Raw pin levels
    output logic      [WIDTH-1:0] syncOut   // Synchronised levels
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1  <= '1;
            syncOut <= '1;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// file: rtl/jtpps_top.sv
// Shared-pin boundary-scan test port, sampled on sys_clk.
// Assumes raw pins and boundary cells of the core outside; test clock is slow.
`include "jtpps_params.svh"
`timescale 1ns/1ps
module jtpps_top #(
    parameter int BSR_LEN = 8
) (
    input  wire logic               sys_clk,            // 125 MHz clock
    input  wire logic               srst,               // Sync reset, active high
    input  wire logic               test_mode_select_n, // Pin, low selects test
    input  wire logic [4:0]         gpioIn,             // Shared pin levels
    input  wire logic [4:0]         coreGpioOut,        // Normal-mode pin data
    input  wire logic [4:0]         coreGpioOe_n,       // Normal-mode enables, low drives
    output logic      [4:0]         gpioOut,            // Shared pin drive data
    output logic      [4:0]         gpioOe_n,           // Shared pin enable, low drives
    output logic      [4:0]         coreGpioIn,         // Pin levels to core
    output logic                    testActive,         // Normal operation halted
    input  wire logic [BSR_LEN-1:0] bsPinIn,            // Levels at scanned pins
    output logic      [BSR_LEN-1:0] bsPinOut,           // Boundary drive values
    output logic                    bsDrive,            // Boundary drives pins
    output logic                    bsHighz             // All outputs floated
);
    ////////////////////////////////////////////////////////////////////////
    logic [5:0] syncd;
    jtpps_sync #(.WIDTH(6)) uSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .asyncIn ({test_mode_select_n, gpioIn}),
        .syncOut (syncd)
    );
    wire       inTest  = ~syncd[5];
    wire       tckS    = syncd[`JTPPS_GPIO_TCK];
    wire       tmsS    = syncd[`JTPPS_GPIO_TMS];
    wire       tdiS    = syncd[`JTPPS_GPIO_TDI];
    wire       trstS_n = syncd[`JTPPS_GPIO_TRST];
    logic      tckPrev;
    wire       tckRise = inTest & tckS & ~tckPrev;
    wire       tckFall = inTest & ~tckS & tckPrev;
    wire       tapRst  = srst | ~inTest | ~trstS_n;

    ////////////////////////////////////////////////////////////////////////
    jtpps_pkg::jtpps_state_t state;
    jtpps_pkg::jtpps_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            jtpps_pkg::TLR: next_state = tmsS ? jtpps_pkg::TLR : jtpps_pkg::RTI;
            jtpps_pkg::RTI: next_state = tmsS ? jtpps_pkg::SDS : jtpps_pkg::RTI;
            jtpps_pkg::SDS: next_state = tmsS ? jtpps_pkg::SIS : jtpps_pkg::CDR;
            jtpps_pkg::CDR: next_state = tmsS ? jtpps_pkg::E1D : jtpps_pkg::SDR;
            jtpps_pkg::SDR: next_state = tmsS ? jtpps_pkg::E1D : jtpps_pkg::SDR;
            jtpps_pkg::E1D: next_state = tmsS ? jtpps_pkg::UDR : jtpps_pkg::PDR;
            jtpps_pkg::PDR: next_state = tmsS ? jtpps_pkg::E2D : jtpps_pkg::PDR;
            jtpps_pkg::E2D: next_state = tmsS ? jtpps_pkg::UDR : jtpps_pkg::SDR;
            jtpps_pkg::UDR: next_state = tmsS ? jtpps_pkg::SDS : jtpps_pkg::RTI;
            jtpps_pkg::SIS: next_state = tmsS ? jtpps_pkg::TLR : jtpps_pkg::CIR;
            jtpps_pkg::CIR: next_state = tmsS ? jtpps_pkg::E1I : jtpps_pkg::SIR;
            jtpps_pkg::SIR: next_state = tmsS ? jtpps_pkg::E1I : jtpps_pkg::SIR;
            jtpps_pkg::E1I: next_state = tmsS ? jtpps_pkg::UIR : jtpps_pkg::PIR;
            jtpps_pkg::PIR: next_state = tmsS ? jtpps_pkg::E2I : jtpps_pkg::PIR;
            jtpps_pkg::E2I: next_state = tmsS ? jtpps_pkg::UIR : jtpps_pkg::SIR;
            jtpps_pkg::UIR: next_state = tmsS ? jtpps_pkg::SDS : jtpps_pkg::RTI;
            default:        next_state = jtpps_pkg::TLR;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    logic [`JTPPS_IR_LEN-1:0] irShift;
    logic [`JTPPS_IR_LEN-1:0] irHold;
    logic [31:0]              drShift;
    logic [BSR_LEN-1:0]       bsrUpd;
    logic                     tdoBit;

    // Instruction decode; unknown codes fall to bypass
    // Decode reads the held code only, so a half-shifted code
    // never reaches the pin controls mid-scan
    wire isExtest  = irHold == `JTPPS_IR_EXTEST;
    wire isSample  = irHold == `JTPPS_IR_SAMPLE;
    wire isPreload = irHold == `JTPPS_IR_PRELOAD;
    wire isIdcode  = irHold == `JTPPS_IR_IDCODE;
    wire isClamp   = irHold == `JTPPS_IR_CLAMP;
    wire isHighz   = irHold == `JTPPS_IR_HIGHZ;
    wire selBsr    = isExtest | isSample | isPreload;
    wire [5:0] drLen = isIdcode ? 6'd32 : (selBsr ? 6'(BSR_LEN) : 6'd1);
    wire [31:0] drCapture = isIdcode ? `JTPPS_IDCODE :
                            (selBsr ? 32'(bsPinIn) : 32'h0000_0000);
    wire [31:0] drShifted = (drShift >> 1) | (32'(tdiS) << (drLen - 6'd1));
    wire [`JTPPS_IR_LEN-1:0] irShifted = {tdiS, irShift[`JTPPS_IR_LEN-1:1]};
    wire inShift = (state == jtpps_pkg::SDR) | (state == jtpps_pkg::SIR);
    wire next_tdo = (state == jtpps_pkg::SIR) ? irShift[0] : drShift[0];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tckPrev <= 1'b0;
        end else begin
            tckPrev <= tckS;
        end
    end

    // Standard clocks TAP on test clock rise; TDO changes on its fall
    always_ff @(posedge sys_clk) begin
        if (tapRst) begin
            state   <= jtpps_pkg::TLR;
            irShift <= `JTPPS_IR_CAPTURE;
            irHold  <= `JTPPS_IR_IDCODE;
            drShift <= 32'h0000_0000;
            bsrUpd  <= '0;
        end else if (tckRise) begin
            state <= next_state;
            if (state == jtpps_pkg::TLR) begin
                irHold <= `JTPPS_IR_IDCODE;
            end
            if (state == jtpps_pkg::CIR) begin
                irShift <= `JTPPS_IR_CAPTURE;
            end
            if (state == jtpps_pkg::SIR) begin
                irShift <= irShifted;
            end
            if (state == jtpps_pkg::UIR) begin
                irHold <= irShift;
            end
            if (state == jtpps_pkg::CDR) begin
                drShift <= drCapture;
            end
            if (state == jtpps_pkg::SDR) begin
                drShift <= drShifted;
            end
            if (state == jtpps_pkg::UDR && selBsr) begin
                bsrUpd <= drShift[BSR_LEN-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (tapRst) begin
            tdoBit <= 1'b0;
        end else if (tckFall) begin
            tdoBit <= next_tdo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // TDO only driven during shift states, floated otherwise
    logic tdoEn;
    always_ff @(posedge sys_clk) begin
        if (tapRst) begin
            tdoEn <= 1'b0;
        end else if (tckFall) begin
            tdoEn <= inShift;
        end
    end

    wire [4:0] testOut  = 5'(tdoBit) << `JTPPS_GPIO_TDO;
    wire [4:0] testOe_n = ~(5'(tdoEn & inTest) << `JTPPS_GPIO_TDO);
    wire [4:0] next_gpioOut  = inTest ? testOut : coreGpioOut;
    wire [4:0] next_gpioOe_n = inTest ? testOe_n : coreGpioOe_n;
    wire       outMode = isExtest | isClamp;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gpioOut    <= 5'h00;
            gpioOe_n   <= 5'h1F;
            coreGpioIn <= 5'h00;
            testActive <= 1'b0;
            bsPinOut   <= '0;
            bsDrive    <= 1'b0;
            bsHighz    <= 1'b0;
        end else begin
            gpioOut    <= next_gpioOut;
            gpioOe_n   <= next_gpioOe_n;
            coreGpioIn <= inTest ? 5'h00 : syncd[4:0];
            testActive <= inTest;
            bsPinOut   <= bsrUpd;
            bsDrive    <= inTest & outMode;
            bsHighz    <= inTest & isHighz;
        end
    end
endmodule

// file: sim/jtpps_monitor.sv
// Port checker for the shared-pin test port.
// Assumes it is bound into every jtpps_top instance.
`timescale 1ns/1ps
module jtpps_monitor #(
    parameter int BSR_LEN = 8
) (
    input wire logic               sys_clk, srst, test_mode_select_n, testActive,
    input wire logic [4:0]         gpioIn, coreGpioOut, coreGpioOe_n, gpioOut, gpioOe_n,
    input wire logic [4:0]         coreGpioIn,
    input wire logic [BSR_LEN-1:0] bsPinIn, bsPinOut,
    input wire logic               bsDrive, bsHighz
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_test_pins_held: assert property (testActive && $past(testActive) |->
        coreGpioIn == 5'h00 && gpioOe_n[4] && gpioOe_n[2:0] == 3'h7) else $error("pins misdriven");
    a_enter_test: assert property ($fell(test_mode_select_n) |-> ##[1:5] testActive)
        else $error("test mode not entered");
    a_leave_test: assert property ($rose(test_mode_select_n) |-> ##[1:5] !testActive)
        else $error("test mode not left");
    a_normal_no_scan: assert property (!testActive |-> !bsDrive && !bsHighz)
        else $error("boundary active in normal mode");
    a_tdo_stands: assert property ((testActive && gpioIn[0]) [*6] |-> $stable(gpioOut[3]))
        else $error("data out moved in clock high");
    a_trst_clears: assert property ((testActive && !gpioIn[4]) [*5] |-> !bsDrive && !bsHighz)
        else $error("mode left after test reset");
    a_mode_exclusive: assert property (bsHighz |-> !bsDrive && testActive)
        else $error("float and drive together");
endmodule
bind jtpps_top jtpps_monitor #(.BSR_LEN(BSR_LEN)) i_jtpps_monitor (.*);

// file: sim/jtpps_jtag_host.sv
// Boundary-scan controller model on the far side of the pins.
// Assumes tdo is the resolved level of pin 3.
`timescale 1ns/1ps
module jtpps_jtag_host (
    output logic      tck,        // Test clock, still between frames
    output logic      tms,        // Mode select
    output logic      tdi,        // Data in
    output logic      testResetN, // Test reset
    input  wire logic tdo         // Level of pin 3
);
    initial {tck, tms, tdi, testResetN} = 4'h5;
    task tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        o = tdo;
        #62.5 tck = 1'b0;
    endtask
    task tlr;
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b1, o);
    endtask
    task trst;
        logic o;
        testResetN = 1'b0;
        #250 testResetN = 1'b1;
        tick(1'b0, 1'b1, o);
    endtask
    task scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        tick(1'b1, ~din[0], o);
        if (ir)
            tick(1'b1, din[0], o);
        tick(1'b0, ~din[0], o);
        tick(1'b0, din[0], o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, ~din[0], o);
        tick(1'b0, din[0], o);
    endtask
endmodule

// file: sim/jtpps_top_bench.sv
// Bench for the shared-pin test port with a controller model.
// Assumes the monitor is bound; undriven data-out pin 3 reads its inverted drive in test mode.
`include "jtpps_params.svh"
`timescale 1ns/1ps
module jtpps_top_bench;
    logic        sys_clk = 1'b0, srst = 1'b1, testModeSelectN = 1'b1;
    logic [4:0]  extPins = 5'h00, coreOut = 5'h00, coreOe_n = 5'h1F, gpioIn, gpioOut, gpioOe_n;
    logic [4:0]  coreIn;
    logic [7:0]  bsIn = 8'h00, bsOut;
    logic [7:0]  lastBs = 8'h00;
    logic        testActive, bsDrive, bsHighz, tck, tms, tdi, tstRstN;
    logic [31:0] seen, dout, r, expQ[$];
    string       nmQ[$];
    int          err_total = 0, check_count = 0, seed = 32'hDAA529C4;
    event        gotEv;
    always #4 sys_clk = ~sys_clk;
    wire [4:0] farPins = testModeSelectN ? extPins : {tstRstN, ~gpioOut[3], tdi, tms, tck};
    assign gpioIn = (~gpioOe_n & gpioOut) | (gpioOe_n & farPins);
    jtpps_top i_jtpps_top (.sys_clk(sys_clk), .srst(srst), .test_mode_select_n(testModeSelectN),
        .gpioIn(gpioIn), .coreGpioOut(coreOut), .coreGpioOe_n(coreOe_n), .gpioOut(gpioOut),
        .gpioOe_n(gpioOe_n), .coreGpioIn(coreIn), .testActive(testActive), .bsPinIn(bsIn),
        .bsPinOut(bsOut), .bsDrive(bsDrive), .bsHighz(bsHighz));
    jtpps_jtag_host i_jtpps_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .testResetN(tstRstN),
        .tdo(gpioIn[3]));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task note(input string nm, input logic [31:0] e);
        nmQ.push_back(nm);
        expQ.push_back(e);
    endtask
    // Edge wait keeps two results out of one time step
    task see(input logic [31:0] s);
        seen = s;
        ->gotEv;
        @(posedge sys_clk);
    endtask
    always @(gotEv) chk(nmQ.pop_front(), seen, expQ.pop_front());
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] c [7] = '{`JTPPS_IR_EXTEST, `JTPPS_IR_SAMPLE, `JTPPS_IR_PRELOAD,
            `JTPPS_IR_IDCODE, `JTPPS_IR_CLAMP, `JTPPS_IR_HIGHZ, `JTPPS_IR_BYPASS};
        wt(3);
        srst = 1'b0;
        repeat (4) begin
            {extPins, coreOut, coreOe_n} = 15'($random(seed));
            wt(5);
            note("normal", 32'({coreOe_n, coreOut, (~coreOe_n & coreOut) | (coreOe_n & extPins)}));
            see(32'({gpioOe_n, gpioOut, coreIn}));
        end
        testModeSelectN = 1'b0;
        wt(6);
        note("entry", 32'h20);
        see(32'({testActive, coreIn}));
        i_jtpps_jtag_host.tlr();
        note("idcode", `JTPPS_IDCODE);
        i_jtpps_jtag_host.scan(1'b0, 32'($random(seed)), 32, dout);
        see(dout);
        foreach (c[k]) begin
            bsIn = 8'($random(seed));
            r = 32'($random(seed));
            note("ir capture", 32'h1);
            i_jtpps_jtag_host.scan(1'b1, 32'(c[k]), 4, dout);
            see(dout);
            wt(6);
            note("mode", 32'({c[k] == `JTPPS_IR_HIGHZ, c[k] == 4'h0 || c[k] == 4'h4}));
            see(32'({bsHighz, bsDrive}));
            note("dr", c[k] < 4'h3 ? 32'(bsIn) : c[k] == 4'h3 ? 32'h01 : 32'({r[6:0], 1'b0}));
            i_jtpps_jtag_host.scan(1'b0, r, 8, dout);
            see(dout);
            wt(6);
            // Non-boundary instructions must leave the last update untouched
            note("update", c[k] < 4'h3 ? 32'(r[7:0]) : 32'(lastBs));
            see(32'(bsOut));
            if (c[k] < 4'h3)
                lastBs = r[7:0];
        end
        i_jtpps_jtag_host.scan(1'b1, 32'(`JTPPS_IR_HIGHZ), 4, dout);
        i_jtpps_jtag_host.trst();
        note("trst mode", 32'h0);
        see(32'({bsHighz, bsDrive}));
        note("trst id", `JTPPS_IDCODE);
        i_jtpps_jtag_host.scan(1'b0, r, 32, dout);
        see(dout);
        testModeSelectN = 1'b1;
        wt(6);
        note("exit", 32'h0);
        see(32'(testActive));
        srst = 1'b1; // Master reset on leaving test mode
        wt(3);
        srst = 1'b0;
        wt(5);
        tally_and_finish;
    end
endmodule
